// file: design/epi_pkg.sv
// epi_pkg: constants for the external pin interrupt controller.
// assumes a 100 MHz core clock and an APB register slave with 32-bit data.
package epi_pkg;
  // ==========================================================
  // register offsets (printed offsets are not all word aligned)
  localparam logic [7:0] EPI_IDX_PIN_CHANGE_MASK_REG = 8'h15;
  localparam logic [7:0] EPI_IDX_CTRL_REG = 8'h35;
  localparam logic [7:0] EPI_IDX_FLAG_REG = 8'h3a;
  localparam logic [7:0] EPI_IDX_EN_REG = 8'h3b;
  localparam logic [9:0] EPI_ADDR_PIN_CHANGE_MASK = {EPI_IDX_PIN_CHANGE_MASK_REG, 2'b00};
  localparam logic [9:0] EPI_ADDR_CTRL = {EPI_IDX_CTRL_REG, 2'b00};
  localparam logic [9:0] EPI_ADDR_FLAG = {EPI_IDX_FLAG_REG, 2'b00};
  localparam logic [9:0] EPI_ADDR_EN = {EPI_IDX_EN_REG, 2'b00};
  localparam int EPI_ADDR_W = 10;
  // ==========================================================
  // field positions
  localparam int EPI_BIT_EXT = 6;
  localparam int EPI_BIT_PC = 5;
  localparam int EPI_NPC = 6;
  localparam logic [7:0] EPI_PIN_CHANGE_MASK_RW = 8'h3f;
  localparam logic [7:0] EPI_CTRL_RW = 8'h03;
  localparam logic [7:0] EPI_RESET_VAL = 8'h00;
  // ==========================================================
  // vector addresses
  localparam int EPI_VEC_W = 4;
  localparam logic [3:0] EPI_VEC_RESET = 4'h0;
  localparam logic [3:0] EPI_VEC_EXT = 4'h1;
  localparam logic [3:0] EPI_VEC_PC = 4'h2;
  localparam logic [3:0] EPI_VEC_LAST = 4'he;
  localparam int EPI_NPERIPH = 12;
  // ==========================================================
  // sense select
  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_t;
endpackage : epi_pkg

// file: design/epi_ctrl.sv
// epi_ctrl: external pin and pin-change interrupt controller with vectors.
// assumes the core handshakes one vector at a time via o_irq_req/i_irq_ack
// and drives its own global enable; pins arrive asynchronously.
//
// How it works
// - fifteen vectors, reset 0x0 through 0xE
// - all reset causes use vector zero
// - pins sensed regardless of their direction
// - masked-in pin toggle raises pin-change request
// - pin change also wakes without clock
// - low level wakes asynchronously from sleep
// - ext pin edges detected only by clocked logic
// - low level requests continuously while low
// - short low during wake gives no interrupt
// - sense select picks level/any/fall/rise
// - pin sampled first; pulses over clock detected
// - enable bit 6 with global enables ext
// - enable bit 5 with global enables change
// - ext flag sets on edge, clears on ack/write-one
// - ext flag held clear in level mode
// - change flag sets, clears on ack/write-one
// - mask bits 5:0 gate inputs, 7:6 zero
// - unused enable/flag bits read zero
`timescale 1ns/10ps
module epi_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [epi_pkg::EPI_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ext_irq_pin,
  input wire logic [epi_pkg::EPI_NPC-1:0] i_pin_change_inputs,
  input wire logic i_global_ie,
  input wire logic [epi_pkg::EPI_NPERIPH-1:0] i_periph_req,
  input wire logic i_reset_pin,
  input wire logic i_por,
  input wire logic i_bor,
  input wire logic i_wdt_reset,
  input wire logic i_irq_ack,
  output logic o_irq_req,
  output logic [epi_pkg::EPI_VEC_W-1:0] o_irq_vector,
  output logic o_wake,
  output logic o_sys_reset_req
);
  import epi_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] pin_change_mask_r;
  logic [1:0] sense_r;
  logic ext_en_r;
  logic pc_en_r;
  logic ext_flag_r;
  logic pc_flag_r;
  epi_sense_t sense;
  assign sense = epi_sense_t'(sense_r);

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;

  // ==========================================================
  // pin synchronisers (pins may be driven by this part as outputs too)
  logic ext_s2_r;
  logic ext_d_r;
  logic [EPI_NPC-1:0] pc_s2_r;
  logic [EPI_NPC-1:0] pc_d_r;

  // the external pin idles high, so its stages reset high and no false
  // falling edge follows reset
  epi_sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) ext_sync_u (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(i_ext_irq_pin),
    .o_sync(ext_s2_r)
  );

  // pin-change stages reset low; the mask is clear after reset, so a
  // pin that differs cannot raise a request
  epi_sync2 #(
    .WIDTH(EPI_NPC),
    .RST_VAL('0)
  ) pc_sync_u (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(i_pin_change_inputs),
    .o_sync(pc_s2_r)
  );

  // previous sampled level, the reference for edge detection
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_d_r <= 1'b1;
    end else begin
      ext_d_r <= ext_s2_r;
    end
  end

  // previous sampled levels, the reference for change detection
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_d_r <= '0;
    end else begin
      pc_d_r <= pc_s2_r;
    end
  end

  // ==========================================================
  // detection
  logic ext_edge;
  always_comb begin
    ext_edge = 1'b0;
    unique case (sense)
      EPI_SENSE_LOW: begin
        ext_edge = 1'b0;
      end
      EPI_SENSE_ANY: begin
        ext_edge = ext_s2_r ^ ext_d_r;
      end
      EPI_SENSE_FALL: begin
        ext_edge = ext_d_r && !ext_s2_r;
      end
      EPI_SENSE_RISE: begin
        ext_edge = !ext_d_r && ext_s2_r;
      end
    endcase
  end

  logic pc_event;
  assign pc_event = |((pc_s2_r ^ pc_d_r) & pin_change_mask_r[EPI_NPC-1:0]);

  // level request follows the synchronised pin, no flag involved
  logic ext_level_req;
  assign ext_level_req = (sense == EPI_SENSE_LOW) && !ext_s2_r;

  // ==========================================================
  // arbitration, lowest vector first
  logic ext_pend;
  logic pc_pend;
  assign ext_pend = ext_en_r && (ext_flag_r || ext_level_req);
  assign pc_pend = pc_en_r && pc_flag_r;

  logic [EPI_VEC_W-1:0] vec_sel;
  logic any_pend;
  always_comb begin
    vec_sel = EPI_VEC_RESET;
    any_pend = 1'b0;
    if (ext_pend) begin
      vec_sel = EPI_VEC_EXT;
      any_pend = 1'b1;
    end else if (pc_pend) begin
      vec_sel = EPI_VEC_PC;
      any_pend = 1'b1;
    end else begin
      for (int i = EPI_NPERIPH - 1; i >= 0; i--) begin
        if (i_periph_req[i]) begin
          vec_sel = EPI_VEC_PC + EPI_VEC_W'(i + 1);
          any_pend = 1'b1;
        end
      end
    end
  end

  // a new request is only launched while none is outstanding
  logic req_launch;
  assign req_launch = !o_irq_req && i_global_ie && any_pend;

  // request stays up until the core acknowledges it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_req <= 1'b0;
    end else if (o_irq_req) begin
      if (i_irq_ack) begin
        o_irq_req <= 1'b0;
      end
    end else if (req_launch) begin
      o_irq_req <= 1'b1;
    end
  end

  // vector is loaded only as a request rises, so it holds still while
  // the request waits; a later, higher source waits for the next turn
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_vector <= EPI_VEC_RESET;
    end else if (req_launch) begin
      o_irq_vector <= vec_sel;
    end
  end

  logic ack_ext;
  logic ack_pc;
  assign ack_ext = o_irq_req && i_irq_ack && (o_irq_vector == EPI_VEC_EXT);
  assign ack_pc = o_irq_req && i_irq_ack && (o_irq_vector == EPI_VEC_PC);

  // software clears a flag by writing one to its bit
  logic flag_wr;
  logic ext_clr_wr;
  logic pc_clr_wr;
  assign flag_wr = wr_acc && (i_paddr == EPI_ADDR_FLAG);
  assign ext_clr_wr = flag_wr && i_pwdata[EPI_BIT_EXT];
  assign pc_clr_wr = flag_wr && i_pwdata[EPI_BIT_PC];

  // ==========================================================
  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_flag_r <= 1'b0;
    end else if (sense == EPI_SENSE_LOW) begin
      ext_flag_r <= 1'b0;
    end else if (ext_edge) begin
      ext_flag_r <= 1'b1;
    end else if (ack_ext || ext_clr_wr) begin
      ext_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_flag_r <= 1'b0;
    end else if (pc_event) begin
      pc_flag_r <= 1'b1;
    end else if (ack_pc || pc_clr_wr) begin
      pc_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  // writes to unmapped addresses select nothing and are dropped
  logic mask_wr;
  logic ctrl_wr;
  logic en_wr;
  assign mask_wr = wr_acc && (i_paddr == EPI_ADDR_PIN_CHANGE_MASK);
  assign ctrl_wr = wr_acc && (i_paddr == EPI_ADDR_CTRL);
  assign en_wr = wr_acc && (i_paddr == EPI_ADDR_EN);

  // reserved mask bits are never stored, so they always read zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_change_mask_r <= EPI_RESET_VAL;
    end else if (mask_wr) begin
      pin_change_mask_r <= i_pwdata[7:0] & EPI_PIN_CHANGE_MASK_RW;
    end
  end

  // changing the sense while the pin moves may yield one stray edge
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sense_r <= EPI_SENSE_LOW;
    end else if (ctrl_wr) begin
      sense_r <= i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_en_r <= 1'b0;
    end else if (en_wr) begin
      ext_en_r <= i_pwdata[EPI_BIT_EXT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_en_r <= 1'b0;
    end else if (en_wr) begin
      pc_en_r <= i_pwdata[EPI_BIT_PC];
    end
  end

  // ==========================================================
  // read path, zero-wait; unmapped addresses read zero with pslverr
  logic mapped;
  logic [7:0] rd_val;
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    unique case (i_paddr)
      EPI_ADDR_PIN_CHANGE_MASK: begin
        rd_val = pin_change_mask_r & EPI_PIN_CHANGE_MASK_RW;
      end
      EPI_ADDR_CTRL: begin
        rd_val = {6'h00, sense_r};
      end
      EPI_ADDR_FLAG: begin
        rd_val = {1'b0, ext_flag_r, pc_flag_r, 5'h00};
      end
      EPI_ADDR_EN: begin
        rd_val = {1'b0, ext_en_r, pc_en_r, 5'h00};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= {24'h00_0000, rd_val};
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  // ==========================================================
  // asynchronous wake: combinational from the raw pins, because the
  // clock may be halted in deep sleep; only a wake source, never a flag
  // level and masked pin toggle relative to last sampled value
  assign o_wake = (ext_en_r && (sense == EPI_SENSE_LOW) && !i_ext_irq_pin)
                  || (pc_en_r && |((i_pin_change_inputs ^ pc_d_r)
                                   & pin_change_mask_r[EPI_NPC-1:0]));
  // a low gone before the clock resumes never reaches the request

  // all reset causes map to vector zero
  assign o_sys_reset_req = i_reset_pin || i_por || i_bor || i_wdt_reset;
  logic unused_rd;
  assign unused_rd = rd_acc;
endmodule : epi_ctrl

// ==========================================================
// two-stage synchroniser for pins from outside the clock domain; only
// the second stage is read by any logic, the first may be metastable
module epi_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= RST_VAL;
    end else begin
      meta_r <= i_async;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sync <= RST_VAL;
    end else begin
      o_sync <= meta_r;
    end
  end
endmodule : epi_sync2

// file: tb/epi_core.sv
// epi_core: stand-in for the core that takes vectors after a set delay.
// assumes it shares the controller clock and reset.
`timescale 1ns/10ps
module epi_core (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic [3:0] i_vec,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic [3:0] o_vec
);
  // ====
  // acceptance: the delay models a slow or prompt core
  logic [3:0] cnt_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {o_ack, o_vec, cnt_r} <= '0;
    end else begin
      o_ack <= i_req && !o_ack && cnt_r == i_lat;
      cnt_r <= (i_req && !o_ack && cnt_r != i_lat) ? cnt_r + 4'h1 : 4'h0;
      if (i_req && !o_ack) o_vec <= i_vec;
    end
  end
endmodule : epi_core

// file: tb/epi_ctrl_chk.sv
// epi_ctrl_chk: checks on the request handshake and register reads.
// assumes it is bound onto epi_ctrl with ports matched by name.
`timescale 1ns/10ps
module epi_ctrl_chk (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [epi_pkg::EPI_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic i_global_ie,
  input wire logic [epi_pkg::EPI_NPERIPH-1:0] i_periph_req,
  input wire logic i_irq_ack,
  input wire logic o_irq_req,
  input wire logic [epi_pkg::EPI_VEC_W-1:0] o_irq_vector
);
  import epi_pkg::*;
  // ====
  // assertions
  logic rd;
  assign rd = i_psel & i_penable & ~i_pwrite;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  chk_req_hold: assert property (
    o_irq_req && !i_irq_ack |=> o_irq_req && $stable(o_irq_vector))
    else $error("request not held");
  chk_ack_drop: assert property (
    o_irq_req && i_irq_ack |=> !o_irq_req) else $error("req after ack");
  chk_vec_range: assert property (
    o_irq_req |-> o_irq_vector inside {[EPI_VEC_EXT:EPI_VEC_LAST]})
    else $error("bad vector");
  chk_ie_gate: assert property (
    $rose(o_irq_req) |-> $past(i_global_ie)) else $error("req while off");
  chk_prio_low: assert property (
    $rose(o_irq_req) && $past(i_periph_req[0]) |-> o_irq_vector <= 4'h3)
    else $error("priority order");
  chk_flag_rsv: assert property (rd && i_paddr == EPI_ADDR_FLAG |->
    o_prdata[31:7] == '0 && o_prdata[4:0] == '0) else $error("flag bits");
  chk_en_rsv: assert property (rd && i_paddr == EPI_ADDR_EN |->
    o_prdata[31:7] == '0 && o_prdata[4:0] == '0) else $error("enable bits");
  chk_mask_rsv: assert property (
    rd && i_paddr == EPI_ADDR_PIN_CHANGE_MASK |-> o_prdata[31:6] == '0)
    else $error("mask bits");
  cover property (i_irq_ack && o_irq_vector == EPI_VEC_EXT);
  cover property (i_irq_ack && o_irq_vector == EPI_VEC_PC);
  cover property (i_irq_ack && o_irq_vector == 4'h3);
endmodule : epi_ctrl_chk

// file: tb/epi_ctrl_test.sv
// epi_ctrl_test: self-checking bench for epi_ctrl over apb.
// assumes epi_pkg, epi_ctrl, epi_core and epi_ctrl_chk compiled first.
`timescale 1ns/10ps
module epi_ctrl_test;
  import epi_pkg::*;
  logic clk = 0, rstn = 0, sel = 0, en = 0, wr = 0, ie = 0, pin = 1;
  logic rdy, err, perr, req, ack, rr;
  logic [9:0] pa = '0;
  logic [31:0] wd = '0, rd, q, rnd = 32'hbf2d;
  logic [5:0] pc = '0;
  logic [11:0] per = '0;
  logic [3:0] rc = '0, lat = 4'h2, vec, av;
  logic [3:0] exp_q[$], got_q[$];
  logic [9:0] ra[4] = '{EPI_ADDR_PIN_CHANGE_MASK, EPI_ADDR_CTRL, EPI_ADDR_FLAG,
    EPI_ADDR_EN};
  logic [7:0] rw[4] = '{8'h3f, 8'h03, 8'h00, 8'h60};
  int n_mismatch = 0, tests_run = 0;
  // ====
  // harness
  initial forever #5 clk = ~clk;
  epi_ctrl dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(pa), .i_pwdata(wd),
    .o_prdata(rd), .o_pready(rdy), .o_pslverr(err), .i_ext_irq_pin(pin),
    .i_pin_change_inputs(pc), .i_global_ie(ie), .i_periph_req(per),
    .i_reset_pin(rc[0]), .i_por(rc[1]), .i_bor(rc[2]), .i_wdt_reset(rc[3]),
    .i_irq_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_wake(),
    .o_sys_reset_req(rr));
  epi_core core_u (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_vec(vec),
    .i_lat(lat), .o_ack(ack), .o_vec(av));
  always @(posedge clk) if (ack === 1'b1) got_q.push_back(av);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic bad(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : bad
  task automatic chk_reg(input logic [31:0] a, e);
    tests_run++;
    if (a !== e) bad("register value");
  endtask : chk_reg
  task automatic chk_vec;
    tests_run++;
    if (got_q.size() != exp_q.size()) bad("vector count");
    else foreach (got_q[i]) if (got_q[i] !== exp_q[i]) bad("vector");
    got_q.delete();
    exp_q.delete();
  endtask : chk_vec
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    cyc(1);
    {sel, en, wr, pa, wd} <= {2'b10, w, a, d};
    cyc(1);
    en <= 1'b1;
    do cyc(1); while (rdy !== 1'b1);
    q = rd;
    perr = err;
    {sel, en} <= 2'b00;
  endtask : apb
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk_reg(q, e);
  endtask : rdc
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // ====
  // scenarios; a hang past the expected run length is cut short here
  initial begin
    #100000;
    bad("timeout");
    finish_test();
  end
  initial begin
    cyc(3);
    rstn <= 1'b1;
    foreach (ra[i]) begin
      rdc(ra[i], '0);
      apb(1'b1, ra[i], '1);
      rdc(ra[i], {24'h0, rw[i]});
    end
    rdc(10'h0, '0);
    chk_reg({31'h0, perr}, 1);
    for (int i = 0; i < 4; i++) begin
      rc <= 4'h1 << i;
      cyc(1);
      chk_reg({31'h0, rr}, 1);
    end
    rc <= '0;
    $display("test registers done");
    ie <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, EPI_ADDR_CTRL, m);
      pin <= 1'b0;
      cyc(m == 1 ? 20 : 2);
      pin <= 1'b1;
      cyc(30);
      if (m != 3) exp_q.push_back(EPI_VEC_EXT);
      if (m != 2) exp_q.push_back(EPI_VEC_EXT);
      chk_vec();
    end
    apb(1'b1, EPI_ADDR_EN, 32'h20);
    repeat (4) begin
      rnd = lfsr(rnd);
      lat <= rnd[19:16];
      apb(1'b1, EPI_ADDR_PIN_CHANGE_MASK, {26'h0, rnd[5:0]});
      pc <= pc ^ rnd[13:8];
      if ((rnd[5:0] & rnd[13:8]) != 0) exp_q.push_back(EPI_VEC_PC);
      cyc(30);
      chk_vec();
    end
    $display("test events done");
    ie <= 1'b0;
    apb(1'b1, EPI_ADDR_EN, 32'h60);
    apb(1'b1, EPI_ADDR_CTRL, 32'h2);
    pin <= 1'b0;
    cyc(5);
    rdc(EPI_ADDR_FLAG, 32'h40);
    apb(1'b1, EPI_ADDR_FLAG, 32'h40);
    rdc(EPI_ADDR_FLAG, '0);
    pin <= 1'b1;
    cyc(3);
    pin <= 1'b0;
    per <= 12'h1;
    cyc(5);
    ie <= 1'b1;
    cyc(40);
    {ie, per} <= '0;
    pin <= 1'b1;
    cyc(20);
    while (got_q.size() > 2) void'(got_q.pop_back());
    exp_q = '{EPI_VEC_EXT, 4'h3};
    chk_vec();
    apb(1'b1, EPI_ADDR_CTRL, '0);
    ie <= 1'b1;
    pin <= 1'b0;
    cyc(40);
    rdc(EPI_ADDR_FLAG, '0);
    pin <= 1'b1;
    cyc(20);
    chk_reg({31'h0, got_q.size() > 1}, 1);
    $display("test priority and level done");
    finish_test();
  end
endmodule : epi_ctrl_test
bind epi_ctrl epi_ctrl_chk chk_u (.*);
